// >>> edma_pkg.sv
package edma_pkg;

    localparam int NCH   = 8;
    localparam int CNT_W = 16;
    localparam int CTRL_W = 22;
    localparam int ADDR_W = 8;

    // Per-channel register block: channel n occupies 16'h10 * n.
    localparam logic [7:0] OFF_SRC  = 8'h00;
    localparam logic [7:0] OFF_DST  = 8'h04;
    localparam logic [7:0] OFF_CTRL = 8'h08;
    localparam logic [7:0] OFF_CNT  = 8'h0C;
    localparam logic [7:0] CH_SPAN  = 8'h80;
    // Global registers.
    localparam logic [7:0] OFF_SWREQ  = 8'h80;
    localparam logic [7:0] OFF_BPRIO  = 8'h84;
    localparam logic [7:0] OFF_CHKIN  = 8'h88;
    localparam logic [7:0] OFF_CHKRES = 8'h8C;
    localparam logic [7:0] OFF_STAT   = 8'h90;

    // Channel control field positions.
    localparam int C_EN    = 0;
    localparam int C_CONT  = 1;
    localparam int C_PRIO  = 2;
    localparam int C_WID   = 3;
    localparam int C_HWEN  = 5;
    localparam int C_RSEL  = 6;
    localparam int C_SMOD  = 9;
    localparam int C_DMOD  = 11;
    localparam int C_SCIRC = 13;
    localparam int C_DCIRC = 17;
    localparam int C_BUS   = 21;
    localparam int C_PEND  = 31;

    localparam logic [1:0] WID_8  = 2'h0;
    localparam logic [1:0] WID_16 = 2'h1;
    localparam logic [1:0] WID_32 = 2'h2;

    localparam logic [1:0] AM_FIX = 2'h0;
    localparam logic [1:0] AM_INC = 2'h1;
    localparam logic [1:0] AM_DEC = 2'h2;

    localparam logic [1:0] SEL_SYS  = 2'h0;
    localparam logic [1:0] SEL_PRIV = 2'h1;
    localparam logic [1:0] SEL_LINK = 2'h2;
    localparam logic [3:0] LINK_SEG = 4'hF;
    localparam logic [31:0] CHK_IN_ADDR = 32'hF000_0100;

    localparam logic [31:0] CRC_POLY = 32'h04C1_1DB7;
    localparam logic [31:0] CRC_INIT = 32'h0000_0000;

    localparam logic [1:0] RESP_OK  = 2'h0;
    localparam logic [1:0] RESP_ERR = 2'h2;

endpackage

// >>> edma_chk_if.sv
`timescale 1ns/10ps
interface edma_chk_if;
    logic        wr;
    logic [31:0] data;
    logic [1:0]  width;
    logic        seed_wr;
    logic [31:0] seed;
    logic [31:0] result;

    modport eng (output wr, data, width, seed_wr, seed, input result);
    modport chk (input wr, data, width, seed_wr, seed, output result);
endinterface

// >>> edma_crc.sv
`timescale 1ns/10ps
module edma_crc
    import edma_pkg::*;
(
    input  wire logic clk,
    input  wire logic rst,
    edma_chk_if.chk   cb
);

    typedef struct packed {
        logic [31:0] crc;
    } edma_crc_st_t;

    edma_crc_st_t q_reg;
    edma_crc_st_t q_next;

    assign cb.result = q_reg.crc;

    // The value is shifted in MSB first with no inversion of start or result,
    // so the checksum does not equal a frame check value of the same data.
    always_comb begin
        logic [31:0] d;
        logic [5:0]  nb;
        logic        fb;
        d = 32'h0000_0000;
        nb = 6'h00;
        fb = 1'b0;
        q_next = q_reg;
        case (cb.width)
            WID_8:   begin d = {cb.data[7:0], 24'h000000}; nb = 6'h08; end
            WID_16:  begin d = {cb.data[15:0], 16'h0000}; nb = 6'h10; end
            default: begin d = cb.data; nb = 6'h20; end
        endcase
        if (cb.seed_wr) begin
            q_next.crc = cb.seed;
        end else if (cb.wr) begin
            for (int i = 0; i < 32; i++) begin
                if (6'(i) < nb) begin
                    fb = q_next.crc[31] ^ d[31-i];
                    q_next.crc = {q_next.crc[30:0], 1'b0} ^ (fb ? CRC_POLY : 32'h0000_0000);
                end
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            q_reg <= '{crc: CRC_INIT};
        end else begin
            q_reg <= q_next;
        end
    end

endmodule

// >>> edma_top.sv
`timescale 1ns/10ps
// Overview of operation
// - Eight independent channels, each running one move at a time.
// - Each channel picks its hardware trigger from eight request lines.
// - Each channel has one of two priority levels for arbitration.
// - Transfers start by software request bit or selected hardware request.
// - Single mode clears the channel enable when the count is used up.
// - Continuous mode keeps the channel enabled and reloads for a rerun.
// - A move waiting on a busy bus is held in a register.
// - Source and destination addresses are full 32 bits.
// - Addresses step after each move, optionally wrapping in a circular buffer.
// - Move width is 8, 16 or 32 bits per channel.
// - Each channel has source, destination, control/status and count registers.
// - A switch routes moves to system, private or link bus ports.
// - Software sets the block's priority on each bus port.
// - System-side requests to the private bus are forwarded there.
// - Link service requests are raised alongside channel completion requests.
// - Any master or a channel may feed the checksum input register.
// - Each checksum input write updates the result register once.
// - Checksum uses the standard 32-bit generator polynomial.
// - Update procedure differs from the frame check procedure.
module edma_top
    import edma_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    input  wire logic [7:0]        hw_req,
    input  wire logic [1:0]        link_sreq,
    output logic                   m_req,
    output logic                   m_we,
    output logic [31:0]            m_addr,
    output logic [31:0]            m_wdata,
    output logic [1:0]             m_size,
    output logic [1:0]             m_sel,
    output logic [5:0]             m_prio,
    input  wire logic              m_ack,
    input  wire logic [31:0]       m_rdata,
    input  wire logic              br_req,
    input  wire logic              br_we,
    input  wire logic [31:0]       br_addr,
    input  wire logic [31:0]       br_wdata,
    output logic                   br_ack,
    output logic [31:0]            br_rdata,
    output logic [NCH+1:0]         srv_req
);

    typedef enum logic [1:0] {ST_IDLE, ST_RD, ST_WR, ST_BR} edma_st_t;

    typedef struct packed {
        logic [NCH-1:0][31:0]       src;
        logic [NCH-1:0][31:0]       dst;
        logic [NCH-1:0][31:0]       cur_src;
        logic [NCH-1:0][31:0]       cur_dst;
        logic [NCH-1:0][CTRL_W-1:0] ctrl;
        logic [NCH-1:0][CNT_W-1:0]  cnt;
        logic [NCH-1:0][CNT_W-1:0]  remain;
        logic [NCH-1:0]             pend;
        logic [5:0]                 bprio;
        logic [7:0]                 hw_s1;
        logic [7:0]                 hw_s2;
        logic [7:0]                 hw_s3;
        edma_st_t                   st;
        logic [2:0]                 ch;
        logic                       m_req;
        logic                       m_we;
        logic [31:0]                m_addr;
        logic [31:0]                m_wdata;
        logic [1:0]                 m_size;
        logic [1:0]                 m_sel;
        logic                       br_ack;
        logic [31:0]                br_rdata;
        logic [NCH+1:0]             srv;
        logic                       aw_full;
        logic                       w_full;
        logic [ADDR_W-1:0]          awaddr;
        logic [31:0]                wdata;
        logic [3:0]                 wstrb;
        logic                       awready;
        logic                       wready;
        logic                       bvalid;
        logic [1:0]                 bresp;
        logic                       arready;
        logic                       rvalid;
        logic [31:0]                rdata;
        logic [1:0]                 rresp;
        logic                       chk_wr;
        logic [31:0]                chk_data;
        logic [1:0]                 chk_width;
        logic                       seed_wr;
        logic [31:0]                seed;
    } edma_st_reg_t;

    edma_st_reg_t q_reg;
    edma_st_reg_t q_next;
    edma_chk_if   chk_bus ();

    edma_crc u_crc (
        .clk (clk),
        .rst (rst),
        .cb  (chk_bus.chk)
    );

    assign chk_bus.wr      = q_reg.chk_wr;
    assign chk_bus.data    = q_reg.chk_data;
    assign chk_bus.width   = q_reg.chk_width;
    assign chk_bus.seed_wr = q_reg.seed_wr;
    assign chk_bus.seed    = q_reg.seed;

    assign s_axi_awready = q_reg.awready;
    assign s_axi_wready  = q_reg.wready;
    assign s_axi_bvalid  = q_reg.bvalid;
    assign s_axi_bresp   = q_reg.bresp;
    assign s_axi_arready = q_reg.arready;
    assign s_axi_rvalid  = q_reg.rvalid;
    assign s_axi_rdata   = q_reg.rdata;
    assign s_axi_rresp   = q_reg.rresp;
    assign m_req         = q_reg.m_req;
    assign m_we          = q_reg.m_we;
    assign m_addr        = q_reg.m_addr;
    assign m_wdata       = q_reg.m_wdata;
    assign m_size        = q_reg.m_size;
    assign m_sel         = q_reg.m_sel;
    assign m_prio        = q_reg.bprio;
    assign br_ack        = q_reg.br_ack;
    assign br_rdata      = q_reg.br_rdata;
    assign srv_req       = q_reg.srv;

    function automatic logic [31:0] edma_wmask(input logic [1:0] w);
        case (w)
            WID_8:   edma_wmask = 32'h0000_00FF;
            WID_16:  edma_wmask = 32'h0000_FFFF;
            default: edma_wmask = 32'hFFFF_FFFF;
        endcase
    endfunction

    // Circular mode keeps the upper address bits fixed and lets only the low
    // circ bits step, so the buffer must be aligned to its own size.
    function automatic logic [31:0] edma_step(input logic [31:0] a, input logic [1:0] mode,
                                              input logic [1:0] w, input logic [3:0] circ);
        logic [31:0] stp;
        logic [31:0] sum;
        logic [31:0] msk;
        stp = (w == WID_8) ? 32'h1 : ((w == WID_16) ? 32'h2 : 32'h4);
        sum = (mode == AM_INC) ? a + stp : ((mode == AM_DEC) ? a - stp : a);
        msk = (circ == 4'h0) ? 32'hFFFF_FFFF : ((32'h1 << circ) - 32'h1);
        edma_step = (a & ~msk) | (sum & msk);
    endfunction

    function automatic logic [1:0] edma_route(input logic [31:0] a, input logic bus);
        if (a[31:28] == LINK_SEG) begin
            edma_route = SEL_LINK;
        end else begin
            edma_route = bus ? SEL_PRIV : SEL_SYS;
        end
    endfunction

    function automatic logic [32:0] edma_rd(input edma_st_reg_t s, input logic [ADDR_W-1:0] a,
                                            input logic [31:0] res);
        logic [2:0] c;
        c = a[6:4];
        edma_rd = {1'b0, 32'h0000_0000};
        if (a < CH_SPAN) begin
            case ({4'h0, a[3:0]})
                OFF_SRC:  edma_rd[31:0] = s.cur_src[c];
                OFF_DST:  edma_rd[31:0] = s.cur_dst[c];
                OFF_CTRL: edma_rd[31:0] = {s.pend[c], 9'h000, s.ctrl[c]};
                default:  edma_rd[31:0] = {16'h0000, s.remain[c]};
            endcase
        end else begin
            case (a)
                OFF_SWREQ:  edma_rd[31:0] = {24'h000000, s.pend};
                OFF_BPRIO:  edma_rd[31:0] = {26'h0000000, s.bprio};
                OFF_CHKIN:  edma_rd[31:0] = res;
                OFF_CHKRES: edma_rd[31:0] = res;
                OFF_STAT:   edma_rd[31:0] = {20'h00000, s.st != ST_IDLE, s.ch, s.pend};
                default:    edma_rd = {1'b1, 32'h0000_0000};
            endcase
        end
    endfunction

    always_comb begin
        logic [7:0]     rise;
        logic [NCH-1:0] ready;
        logic [NCH-1:0] setp;
        logic [2:0]     g_hi;
        logic [2:0]     g_lo;
        logic           hit_hi;
        logic           hit_lo;
        logic [2:0]     c;
        logic [32:0]    rd;
        logic [31:0]    val;
        logic           do_wr;
        logic           fin;
        rise = 8'h00;
        ready = '0;
        setp = '0;
        g_hi = 3'h0;
        g_lo = 3'h0;
        hit_hi = 1'b0;
        hit_lo = 1'b0;
        c = q_reg.ch;
        rd = '0;
        val = 32'h0000_0000;
        do_wr = 1'b0;
        fin = 1'b0;
        q_next = q_reg;
        q_next.srv = '0;
        q_next.br_ack = 1'b0;
        q_next.chk_wr = 1'b0;
        q_next.seed_wr = 1'b0;

        // Only the second and third stages feed the edge detector.
        q_next.hw_s1 = hw_req;
        q_next.hw_s2 = q_reg.hw_s1;
        q_next.hw_s3 = q_reg.hw_s2;
        rise = q_reg.hw_s2 & ~q_reg.hw_s3;
        q_next.srv[NCH+1:NCH] = link_sreq;

        for (int i = 0; i < NCH; i++) begin
            setp[i] = q_reg.ctrl[i][C_HWEN] && rise[q_reg.ctrl[i][C_RSEL +: 3]];
            ready[i] = q_reg.pend[i] && q_reg.ctrl[i][C_EN];
        end
        for (int i = NCH - 1; i >= 0; i--) begin
            if (ready[i] && q_reg.ctrl[i][C_PRIO]) begin
                g_hi = 3'(i);
                hit_hi = 1'b1;
            end
            if (ready[i] && !q_reg.ctrl[i][C_PRIO]) begin
                g_lo = 3'(i);
                hit_lo = 1'b1;
            end
        end

        case (q_reg.st)
            ST_IDLE: begin
                if (br_req && !q_reg.br_ack) begin
                    q_next.st = ST_BR;
                    q_next.m_req = 1'b1;
                    q_next.m_we = br_we;
                    q_next.m_addr = br_addr;
                    q_next.m_wdata = br_wdata;
                    q_next.m_size = WID_32;
                    q_next.m_sel = SEL_PRIV;
                end else if (hit_hi || hit_lo) begin
                    c = hit_hi ? g_hi : g_lo;
                    q_next.ch = c;
                    q_next.pend[c] = 1'b0;
                    q_next.st = ST_RD;
                    q_next.m_req = 1'b1;
                    q_next.m_we = 1'b0;
                    q_next.m_addr = q_reg.cur_src[c];
                    q_next.m_size = q_reg.ctrl[c][C_WID +: 2];
                    q_next.m_sel = edma_route(q_reg.cur_src[c], q_reg.ctrl[c][C_BUS]);
                end
            end
            ST_RD: begin
                // The move stays parked in the request registers until the bus answers.
                if (m_ack) begin
                    val = m_rdata & edma_wmask(q_reg.ctrl[c][C_WID +: 2]);
                    if (q_reg.cur_dst[c] == CHK_IN_ADDR) begin
                        q_next.chk_wr = 1'b1;
                        q_next.chk_data = val;
                        q_next.chk_width = q_reg.ctrl[c][C_WID +: 2];
                        q_next.m_req = 1'b0;
                        q_next.st = ST_IDLE;
                        fin = 1'b1;
                    end else begin
                        q_next.st = ST_WR;
                        q_next.m_we = 1'b1;
                        q_next.m_addr = q_reg.cur_dst[c];
                        q_next.m_wdata = val;
                        q_next.m_sel = edma_route(q_reg.cur_dst[c], q_reg.ctrl[c][C_BUS]);
                    end
                end
            end
            ST_WR: begin
                if (m_ack) begin
                    q_next.m_req = 1'b0;
                    q_next.m_we = 1'b0;
                    q_next.st = ST_IDLE;
                    fin = 1'b1;
                end
            end
            ST_BR: begin
                if (m_ack) begin
                    q_next.m_req = 1'b0;
                    q_next.m_we = 1'b0;
                    q_next.br_ack = 1'b1;
                    q_next.br_rdata = m_rdata;
                    q_next.st = ST_IDLE;
                end
            end
            default: begin
                q_next.st = ST_IDLE;
                q_next.m_req = 1'b0;
            end
        endcase

        if (fin) begin
            q_next.cur_src[c] = edma_step(q_reg.cur_src[c], q_reg.ctrl[c][C_SMOD +: 2],
                                          q_reg.ctrl[c][C_WID +: 2],
                                          q_reg.ctrl[c][C_SCIRC +: 4]);
            q_next.cur_dst[c] = edma_step(q_reg.cur_dst[c], q_reg.ctrl[c][C_DMOD +: 2],
                                          q_reg.ctrl[c][C_WID +: 2],
                                          q_reg.ctrl[c][C_DCIRC +: 4]);
            q_next.remain[c] = q_reg.remain[c] - CNT_W'(1);
            if (q_reg.remain[c] <= CNT_W'(1)) begin
                q_next.srv[c] = 1'b1;
                q_next.remain[c] = q_reg.cnt[c];
                q_next.cur_src[c] = q_reg.src[c];
                q_next.cur_dst[c] = q_reg.dst[c];
                if (!q_reg.ctrl[c][C_CONT]) begin
                    q_next.ctrl[c][C_EN] = 1'b0;
                end
            end
        end

        // Register slave: address and data are caught independently.
        if (s_axi_awvalid && q_reg.awready) begin
            q_next.aw_full = 1'b1;
            q_next.awready = 1'b0;
            q_next.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && q_reg.wready) begin
            q_next.w_full = 1'b1;
            q_next.wready = 1'b0;
            q_next.wdata = s_axi_wdata;
            q_next.wstrb = s_axi_wstrb;
        end
        // A software register write waits one cycle if a channel feeds the checker.
        do_wr = q_reg.aw_full && q_reg.w_full && !q_reg.bvalid && !q_next.chk_wr;
        if (do_wr) begin
            rd = edma_rd(q_reg, q_reg.awaddr, chk_bus.result);
            for (int b = 0; b < 4; b++) begin
                val[8*b +: 8] = q_reg.wstrb[b] ? q_reg.wdata[8*b +: 8] : rd[8*b +: 8];
            end
            c = q_reg.awaddr[6:4];
            q_next.bvalid = 1'b1;
            q_next.bresp = rd[32] ? RESP_ERR : RESP_OK;
            q_next.aw_full = 1'b0;
            q_next.w_full = 1'b0;
            if (q_reg.awaddr < CH_SPAN) begin
                case ({4'h0, q_reg.awaddr[3:0]})
                    OFF_SRC: begin
                        q_next.src[c] = val;
                        q_next.cur_src[c] = val;
                    end
                    OFF_DST: begin
                        q_next.dst[c] = val;
                        q_next.cur_dst[c] = val;
                    end
                    OFF_CTRL: begin
                        q_next.ctrl[c] = val[CTRL_W-1:0];
                        if (val[C_EN] && !q_reg.ctrl[c][C_EN]) begin
                            q_next.cur_src[c] = q_reg.src[c];
                            q_next.cur_dst[c] = q_reg.dst[c];
                            q_next.remain[c] = q_reg.cnt[c];
                        end
                    end
                    default: begin
                        q_next.cnt[c] = val[CNT_W-1:0];
                        q_next.remain[c] = val[CNT_W-1:0];
                    end
                endcase
            end else begin
                case (q_reg.awaddr)
                    OFF_SWREQ: setp = setp | val[NCH-1:0];
                    OFF_BPRIO: q_next.bprio = val[5:0];
                    OFF_CHKIN: begin
                        q_next.chk_wr = 1'b1;
                        q_next.chk_data = val;
                        q_next.chk_width = WID_32;
                    end
                    OFF_CHKRES: begin
                        q_next.seed_wr = 1'b1;
                        q_next.seed = val;
                    end
                    default: ;
                endcase
            end
        end
        if (q_reg.bvalid && s_axi_bready) begin
            q_next.bvalid = 1'b0;
            q_next.awready = 1'b1;
            q_next.wready = 1'b1;
        end
        q_next.pend = q_next.pend | setp;

        if (s_axi_arvalid && q_reg.arready) begin
            rd = edma_rd(q_reg, s_axi_araddr, chk_bus.result);
            q_next.arready = 1'b0;
            q_next.rvalid = 1'b1;
            q_next.rdata = rd[31:0];
            q_next.rresp = rd[32] ? RESP_ERR : RESP_OK;
        end
        if (q_reg.rvalid && s_axi_rready) begin
            q_next.rvalid = 1'b0;
            q_next.arready = 1'b1;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            q_reg <= '0;
            q_reg.awready <= 1'b1;
            q_reg.wready <= 1'b1;
            q_reg.arready <= 1'b1;
        end else begin
            q_reg <= q_next;
        end
    end

endmodule

// >>> edma_bus_model.sv
`timescale 1ns/10ps
module edma_bus_model (
    input  logic        clk,
    input  logic        rst,
    input  logic        m_req,
    input  logic        m_we,
    input  logic [31:0] m_addr,
    input  logic [31:0] m_wdata,
    input  logic        slow,
    output logic        m_ack,
    output logic [31:0] m_rdata,
    output logic [31:0] wr_data,
    output int          wr_cnt
);
    logic [1:0] dly;
    // Reads return the inverted address, and the data bus toggles between acks.
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            {m_ack, m_rdata, dly, wr_data} <= '0;
            wr_cnt <= 0;
        end else if (m_req && !m_ack && dly >= {slow, slow}) begin
            {m_ack, m_rdata, dly} <= {1'h1, ~m_addr, 2'h0};
            if (m_we) wr_data <= m_wdata;
            if (m_we) wr_cnt <= wr_cnt + 1;
        end else begin
            {m_ack, m_rdata} <= {1'h0, ~m_rdata};
            dly <= (m_req && !m_ack) ? dly + 2'h1 : 2'h0;
        end
    end
endmodule

// >>> edma_top_asserts.sv
`timescale 1ns/10ps
module edma_top_asserts
    import edma_pkg::*;
(
    input logic           clk,
    input logic           rst,
    input logic           m_req,
    input logic [31:0]    m_addr,
    input logic [1:0]     m_size,
    input logic [1:0]     m_sel,
    input logic           m_ack,
    input logic           br_ack,
    input logic [1:0]     link_sreq,
    input logic [NCH+1:0] srv_req
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    AST_HOLD: assert property (m_req && !m_ack |=> m_req && $stable(m_addr))
        else $error("move not held");
    AST_LINK: assert property (srv_req[9:8] == $past(link_sreq)) else $error("link");
    AST_SEG: assert property (m_req && m_addr[31:28] == 4'hF |-> m_sel == 2'h2)
        else $error("route");
    AST_WID: assert property (m_req |-> m_size != 2'h3) else $error("width");
    AST_ONE: assert property ($onehot0(srv_req[7:0])) else $error("two done");
    AST_PULSE: assert property (|srv_req[7:0] |=> srv_req[7:0] == 8'h0)
        else $error("done not a pulse");
    AST_DONE: assert property (|srv_req[7:0] |-> $past(m_ack) && !m_req)
        else $error("done without ack");
    AST_BRIDGE: assert property (br_ack |-> $past(m_ack) && $past(m_sel) == 2'h1)
        else $error("bridge");
endmodule
bind edma_top edma_top_asserts u_edma_top_asserts (.*);

// >>> tb_edma_top.sv
`timescale 1ns/10ps
module tb_edma_top
    import edma_pkg::*;
;
    logic        clk, rst, slow, m_req, m_we, m_ack, br_req, br_we, br_ack;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [1:0]  s_axi_bresp, s_axi_rresp, link_sreq, m_size, m_sel;
    logic [3:0]  s_axi_wstrb;
    logic [5:0]  m_prio;
    logic [7:0]  s_axi_awaddr, s_axi_araddr, hw_req;
    logic [9:0]  srv_req, srv_seen;
    logic [31:0] s_axi_wdata, s_axi_rdata, m_addr, m_wdata, m_rdata, wr_data;
    logic [31:0] br_addr, br_wdata, br_rdata;
    int          n_mismatch, n_compared, wr_cnt;
    edma_top u_edma_top (.*);
    edma_bus_model u_edma_bus_model (.*);
    always #5 clk = ~clk;
    always @(posedge clk) srv_seen <= rst ? 10'h0 : srv_seen | srv_req;
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected %0t %h %h", $time, got, exp);
        end
    endtask
    task automatic io(input logic w, input logic [7:0] a, input logic [31:0] d);
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= {a, a, d};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {3{w}};
        {s_axi_arvalid, s_axi_rready} <= {2{!w}};
        do begin
            @(posedge clk);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
        end while (!(w ? s_axi_bvalid : s_axi_rvalid));
        {s_axi_bready, s_axi_rready} <= 2'h0;
        if (!w) cmp(s_axi_rdata, d);
        cmp(w ? s_axi_bresp : s_axi_rresp, (a > OFF_STAT) ? RESP_ERR : RESP_OK);
        @(posedge clk);
    endtask
    function automatic logic [31:0] crc(input logic [31:0] c, input logic [31:0] d);
        for (int i = 31; i >= 0; i--) c = {c[30:0], 1'h0} ^ ((c[31] ^ d[i]) ? CRC_POLY : 32'h0);
        return c;
    endfunction
    task automatic stop_test;
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    initial begin
        #100us;
        n_mismatch++;
        stop_test;
    end
    initial begin
        {clk, rst, slow, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 6'h18;
        {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, hw_req, link_sreq} = '0;
        {br_req, br_we, br_addr, br_wdata, s_axi_wdata, n_mismatch, n_compared} = '0;
        s_axi_wstrb = 4'hF;
        repeat (5) @(posedge clk);
        rst <= 1'h0;
        io(0, 8'h94, 32'h0);
        io(1, OFF_SRC, 32'h100);
        io(1, OFF_DST, 32'h200);
        io(1, OFF_CNT, 32'h2);
        io(1, OFF_CTRL, 32'hA11);
        io(1, OFF_SWREQ, 32'h1);
        for (int i = 0; i < 99 && wr_cnt < 1; i++) @(posedge clk);
        cmp(wr_cnt, 32'h1);
        io(0, OFF_CNT, 32'h1);
        slow <= 1'h0;
        io(1, OFF_SWREQ, 32'h1);
        for (int i = 0; i < 99 && !srv_seen[0]; i++) @(posedge clk);
        cmp(wr_data, ~32'h104);
        io(0, OFF_CTRL, 32'hA10);
        // Re-enabling reloads the start addresses; request line 3 alone must start one move.
        io(1, OFF_CTRL, 32'hAF1);
        hw_req <= 8'h08;
        for (int i = 0; i < 99 && wr_cnt < 3; i++) @(posedge clk);
        hw_req <= 8'h00;
        cmp(wr_data, ~32'h100);
        io(1, OFF_BPRIO, 32'h2D);
        cmp(m_prio, 32'h2D);
        io(1, OFF_SRC + 8'h10, 32'hF000_0040);
        io(1, OFF_DST + 8'h10, CHK_IN_ADDR);
        io(1, OFF_CNT + 8'h10, 32'h1);
        io(1, OFF_CTRL + 8'h10, 32'h213);
        io(1, OFF_SWREQ, 32'h2);
        for (int i = 0; i < 99 && !srv_seen[1]; i++) @(posedge clk);
        io(0, OFF_CTRL + 8'h10, 32'h213);
        io(0, OFF_CHKRES, crc(32'h0, ~32'hF000_0040));
        io(1, OFF_CHKIN, 32'h1234_5678);
        io(0, OFF_CHKRES, crc(crc(32'h0, ~32'hF000_0040), 32'h1234_5678));
        link_sreq <= 2'h2;
        @(posedge clk);
        {link_sreq, br_addr, br_req} <= {2'h0, 32'h10, 1'h1};
        do @(posedge clk); while (!br_ack);
        br_req <= 1'h0;
        cmp(br_rdata, ~32'h10);
        cmp(32'(srv_seen), 32'h203);
        stop_test;
    end
endmodule
